//--- src/psc_pkg.sv
/*
 Constants, opcodes and field layout of the pattern sequencer core.
 Assumes a 32-bit instruction word whose encoding is chosen by this core.
*/
package psc_pkg;
   localparam int DATA_W = 16;
   localparam int NREG = 8;
   localparam int NPORT = 4;
   localparam int RAM_WORDS = 128;
   localparam int FIFO_DEPTH = 256;
   localparam int FIFO_THRESH = 128;
   localparam int PROG_DEPTH = 3584;
   localparam int PC_W = 12;
   localparam int BR_SLOTS = 2;
   localparam int PBUS_RD_CYC = 4;
   localparam int ANN_W = 24;
   // Field positions inside an instruction word.
   localparam int OP_LO = 26;
   localparam int RD_LO = 23;
   localparam int RS_LO = 20;
   localparam int SEL_LO = 18;
   localparam int PS_LO = 16;
   localparam int WP_LO = 24;
   localparam int DUR_LO = 16;
   localparam int MINV_BIT = 4;
   // Source selector codes.
   localparam logic [1:0] SEL_REG = 2'h0;
   localparam logic [1:0] SEL_ACC = 2'h1;
   localparam logic [1:0] SEL_PORT = 2'h2;
   localparam logic [1:0] SEL_IMM = 2'h3;
   // Opcodes.
   localparam logic [5:0] OP_NOP = 6'h00;
   localparam logic [5:0] OP_HALT = 6'h01;
   localparam logic [5:0] OP_MOVR = 6'h02;
   localparam logic [5:0] OP_MOVA = 6'h03;
   localparam logic [5:0] OP_ADD = 6'h04;
   localparam logic [5:0] OP_SUB = 6'h05;
   localparam logic [5:0] OP_AND = 6'h06;
   localparam logic [5:0] OP_OR = 6'h07;
   localparam logic [5:0] OP_XOR = 6'h08;
   localparam logic [5:0] OP_ADDR = 6'h09;
   localparam logic [5:0] OP_CMP = 6'h0A;
   localparam logic [5:0] OP_JMP = 6'h0B;
   localparam logic [5:0] OP_JL = 6'h0C;
   localparam logic [5:0] OP_JNZ = 6'h0D;
   localparam logic [5:0] OP_JZ = 6'h0E;
   localparam logic [5:0] OP_OUTP = 6'h0F;
   localparam logic [5:0] OP_DIR = 6'h10;
   localparam logic [5:0] OP_WAVE = 6'h11;
   localparam logic [5:0] OP_WAIT = 6'h12;
   localparam logic [5:0] OP_MSET = 6'h13;
   localparam logic [5:0] OP_MATCH = 6'h14;
   localparam logic [5:0] OP_FIFO = 6'h15;
   localparam logic [5:0] OP_FLUSH = 6'h16;
   localparam logic [5:0] OP_ANN = 6'h17;
   localparam logic [5:0] OP_ST = 6'h18;
   localparam logic [5:0] OP_LD = 6'h19;
   localparam logic [5:0] OP_PWR = 6'h1A;
   localparam logic [5:0] OP_PRD = 6'h1B;
   typedef enum logic [1:0] {
      PSC_RUN, PSC_DELAY, PSC_MATCH, PSC_PRD
   } psc_mode_t;
endpackage

//--- src/psc_core.sv
/*
 Pattern sequencer core: one instruction per clock, four 16-bit ports,
 match and delay stalls, output FIFO toward the host bridge.
 Assumes the program is loaded over the prog_* port while halted and
 that host-side signals are on clk_sys; pins pass two flip-flops.
*/
`timescale 1ns/1ps
module psc_core #(
   parameter int PROG_DEPTH = psc_pkg::PROG_DEPTH,
   parameter int FIFO_DEPTH = psc_pkg::FIFO_DEPTH,
   parameter int FIFO_THRESH = psc_pkg::FIFO_THRESH
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic prog_we,
   input wire logic [11:0] prog_addr,
   input wire logic [31:0] prog_wdata,
   input wire logic core_start,
   output logic core_running,
   input wire logic [3:0][15:0] port_in,
   output logic [3:0][15:0] port_out,
   output logic [3:0][15:0] port_oe,
   output logic [15:0] pbus_addr,
   output logic [15:0] pbus_dout,
   output logic pbus_oe,
   input wire logic [15:0] pbus_din,
   output logic pbus_rd_n,
   output logic pbus_wr_n,
   output logic host_valid,
   input wire logic host_ready,
   output logic [15:0] host_data,
   output logic host_xfer,
   output logic announce_valid,
   output logic [23:0] announce_count,
   input wire logic [15:0] hgpio_wdata,
   input wire logic [15:0] hgpio_dir,
   input wire logic [15:0] hgpio_in,
   output logic [15:0] hgpio_out,
   output logic [15:0] hgpio_oe,
   output logic [15:0] hgpio_rdata
);
   localparam int FA_W = $clog2(FIFO_DEPTH);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [11:0] pc;
      logic run;
      logic [1:0] br_cnt;
      logic [11:0] br_tgt;
      psc_pkg::psc_mode_t mode;
      logic [23:0] cnt;
      logic [2:0] prd_dst;
      logic [7:0][15:0] r;
      logic [15:0] acc;
      logic z;
      logic lt;
      logic [7:0] dir;
      logic [3:0][15:0] pout;
      logic [15:0] mmask;
      logic [15:0] minv;
      logic [15:0] mpat;
      logic [1:0] mport;
      logic [3:0][15:0] psync1;
      logic [3:0][15:0] psync2;
      logic [15:0] dsync1;
      logic [15:0] dsync2;
      logic [15:0] hsync1;
      logic [15:0] hsync2;
      logic [FA_W-1:0] wp;
      logic [FA_W-1:0] rp;
      logic [FA_W:0] fcnt;
      logic xfer;
      logic ovalid;
      logic [15:0] odata;
      logic annv;
      logic [23:0] annc;
      logic [15:0] paddr;
      logic [15:0] pdout;
      logic poe;
      logic prd;
      logic pwr;
      logic [15:0] hout;
      logic [15:0] hoe;
   } psc_state_t;

   psc_state_t s_reg;
   psc_state_t s_next;
   logic [31:0] prog_mem [PROG_DEPTH];
   logic [15:0] ram_mem [psc_pkg::RAM_WORDS];
   logic [15:0] fifo_mem [FIFO_DEPTH];
   logic [31:0] ins;
   logic [5:0] op;
   logic [15:0] imm;
   logic [15:0] src;
   logic [16:0] alu;
   logic issue;
   logic push;
   logic pop;
   logic hit;
   logic ram_we;
   logic [15:0] ram_rd;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      ins = prog_mem[s_reg.pc];
      op = ins[psc_pkg::OP_LO+:6];
      imm = ins[15:0];
      ram_we = 1'b0;
      ram_rd = ram_mem[imm[6:0]];
      alu = 17'h00000;
      s_next.annv = 1'b0;
      s_next.pwr = 1'b0;
      s_next.poe = 1'b0;
      s_next.psync1 = port_in;
      s_next.psync2 = s_reg.psync1;
      s_next.dsync1 = pbus_din;
      s_next.dsync2 = s_reg.dsync1;
      s_next.hsync1 = hgpio_in;
      s_next.hsync2 = s_reg.hsync1;
      s_next.hout = hgpio_wdata;
      s_next.hoe = hgpio_dir;
      case (ins[psc_pkg::SEL_LO+:2])
         psc_pkg::SEL_REG: src = s_reg.r[ins[psc_pkg::RS_LO+:3]];
         psc_pkg::SEL_ACC: src = s_reg.acc;
         psc_pkg::SEL_PORT: src = s_reg.psync2[ins[psc_pkg::PS_LO+:2]];
         default: src = imm;
      endcase
      hit = (((s_reg.psync2[s_reg.mport] ^ s_reg.minv) ^ s_reg.mpat)
            & s_reg.mmask) == 16'h0000;
      issue = s_reg.run && s_reg.mode == psc_pkg::PSC_RUN
         && !(op == psc_pkg::OP_FIFO && s_reg.fcnt == FIFO_DEPTH);
      push = issue && op == psc_pkg::OP_FIFO;
      pop = s_reg.xfer && s_reg.fcnt != '0
         && (!s_reg.ovalid || host_ready);
      case (s_reg.mode)
         psc_pkg::PSC_DELAY: begin
            s_next.cnt = s_reg.cnt - 24'h000001;
            if (s_reg.cnt == 24'h000001) begin
               s_next.mode = psc_pkg::PSC_RUN;
            end
         end
         psc_pkg::PSC_MATCH: begin
            if (hit) begin
               s_next.mode = psc_pkg::PSC_RUN;
            end
         end
         psc_pkg::PSC_PRD: begin
            s_next.cnt = s_reg.cnt - 24'h000001;
            if (s_reg.cnt == 24'h000001) begin
               s_next.r[s_reg.prd_dst] = s_reg.dsync2;
               s_next.prd = 1'b0;
               s_next.mode = psc_pkg::PSC_RUN;
            end
         end
         default: ;
      endcase
      if (issue) begin
         s_next.pc = s_reg.pc + 12'h001;
         if (s_reg.br_cnt != 2'h0) begin
            s_next.br_cnt = s_reg.br_cnt - 2'h1;
            if (s_reg.br_cnt == 2'h1) begin
               s_next.pc = s_reg.br_tgt;
            end
         end
         case (op)
            psc_pkg::OP_HALT: s_next.run = 1'b0;
            psc_pkg::OP_MOVR: s_next.r[ins[psc_pkg::RD_LO+:3]] = src;
            psc_pkg::OP_MOVA: s_next.acc = src;
            psc_pkg::OP_ADD, psc_pkg::OP_SUB, psc_pkg::OP_AND,
            psc_pkg::OP_OR, psc_pkg::OP_XOR: begin
               case (op)
                  psc_pkg::OP_ADD: alu = {1'b0, s_reg.acc} + {1'b0, src};
                  psc_pkg::OP_SUB: alu = {1'b0, s_reg.acc} - {1'b0, src};
                  psc_pkg::OP_AND: alu = {1'b0, s_reg.acc & src};
                  psc_pkg::OP_OR: alu = {1'b0, s_reg.acc | src};
                  default: alu = {1'b0, s_reg.acc ^ src};
               endcase
               s_next.acc = alu[15:0];
               s_next.z = alu[15:0] == 16'h0000;
            end
            psc_pkg::OP_ADDR: begin
               alu = {1'b0, s_reg.r[ins[psc_pkg::RD_LO+:3]]} + {1'b0, imm};
               s_next.r[ins[psc_pkg::RD_LO+:3]] = alu[15:0];
               s_next.z = alu[15:0] == 16'h0000;
            end
            psc_pkg::OP_CMP: begin
               s_next.z = s_reg.r[ins[psc_pkg::RD_LO+:3]] == imm;
               s_next.lt = s_reg.r[ins[psc_pkg::RD_LO+:3]] < imm;
               if (ins[psc_pkg::SEL_LO+:2] == psc_pkg::SEL_ACC) begin
                  s_next.z = s_reg.acc == imm;
                  s_next.lt = s_reg.acc < imm;
               end
            end
            psc_pkg::OP_JMP, psc_pkg::OP_JL, psc_pkg::OP_JNZ,
            psc_pkg::OP_JZ: begin
               if (s_reg.br_cnt == 2'h0 && (op == psc_pkg::OP_JMP
                   || (op == psc_pkg::OP_JL && s_reg.lt)
                   || (op == psc_pkg::OP_JNZ && !s_reg.z)
                   || (op == psc_pkg::OP_JZ && s_reg.z))) begin
                  s_next.br_cnt = 2'(psc_pkg::BR_SLOTS);
                  s_next.br_tgt = imm[11:0];
               end
            end
            psc_pkg::OP_OUTP: s_next.pout[ins[psc_pkg::RD_LO+:2]] = src;
            psc_pkg::OP_DIR: s_next.dir = imm[7:0];
            psc_pkg::OP_WAVE: begin
               s_next.pout[ins[psc_pkg::WP_LO+:2]] = imm;
               s_next.cnt = {16'h0000, ins[psc_pkg::DUR_LO+:8] - 8'h01};
               if (ins[psc_pkg::DUR_LO+:8] > 8'h01) begin
                  s_next.mode = psc_pkg::PSC_DELAY;
               end
            end
            psc_pkg::OP_WAIT: begin
               s_next.cnt = ins[23:0] - 24'h000001;
               if (ins[23:0] > 24'h000001) begin
                  s_next.mode = psc_pkg::PSC_DELAY;
               end
            end
            psc_pkg::OP_MSET: begin
               s_next.mmask[imm[3:0]] = 1'b1;
               s_next.minv[imm[3:0]] = imm[psc_pkg::MINV_BIT];
            end
            psc_pkg::OP_MATCH: begin
               s_next.mport = ins[psc_pkg::WP_LO+:2];
               s_next.mpat = imm;
               s_next.mode = psc_pkg::PSC_MATCH;
            end
            psc_pkg::OP_FLUSH: s_next.xfer = 1'b1;
            psc_pkg::OP_ANN: begin
               s_next.annv = 1'b1;
               s_next.annc = ins[23:0];
            end
            psc_pkg::OP_ST: ram_we = 1'b1;
            psc_pkg::OP_LD: s_next.r[ins[psc_pkg::RD_LO+:3]] = ram_rd;
            psc_pkg::OP_PWR: begin
               s_next.paddr = imm;
               s_next.pdout = src;
               s_next.poe = 1'b1;
               s_next.pwr = 1'b1;
            end
            psc_pkg::OP_PRD: begin
               s_next.paddr = imm;
               s_next.prd = 1'b1;
               s_next.prd_dst = ins[psc_pkg::RD_LO+:3];
               s_next.cnt = 24'(psc_pkg::PBUS_RD_CYC);
               s_next.mode = psc_pkg::PSC_PRD;
            end
            default: ;
         endcase
      end
      if (s_reg.ovalid && host_ready) begin
         s_next.ovalid = 1'b0;
      end
      if (pop) begin
         s_next.odata = fifo_mem[s_reg.rp];
         s_next.ovalid = 1'b1;
         s_next.rp = s_reg.rp + 1'b1;
      end
      if (push) begin
         s_next.wp = s_reg.wp + 1'b1;
      end
      s_next.fcnt = s_reg.fcnt + {{FA_W{1'b0}}, push}
         - {{FA_W{1'b0}}, pop};
      if (s_reg.xfer && s_reg.fcnt == '0 && !(issue
          && op == psc_pkg::OP_FLUSH)) begin
         s_next.xfer = 1'b0;
      end
      if (s_reg.fcnt >= FIFO_THRESH) begin
         s_next.xfer = 1'b1;
      end
      if (core_start) begin
         s_next.run = 1'b1;
         s_next.pc = 12'h000;
         s_next.br_cnt = 2'h0;
         s_next.mode = psc_pkg::PSC_RUN;
         s_next.prd = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Registers and memories
   // ----------------------------------------------------------------
   // clk_sys is the PLL output; frequency is set outside.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
      if (prog_we) begin
         prog_mem[prog_addr] <= prog_wdata;
      end
      if (ram_we) begin
         ram_mem[imm[6:0]] <= src;
      end
      if (push) begin
         fifo_mem[s_reg.wp] <= src;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // byte-wise direction
   for (genvar p = 0; p < psc_pkg::NPORT; p++) begin : g_port
      assign port_oe[p] = {{8{s_reg.dir[2*p+1]}}, {8{s_reg.dir[2*p]}}};
   end
   assign port_out = s_reg.pout;
   assign core_running = s_reg.run;
   assign pbus_addr = s_reg.paddr;
   assign pbus_dout = s_reg.pdout;
   assign pbus_oe = s_reg.poe;
   assign pbus_rd_n = ~s_reg.prd;
   assign pbus_wr_n = ~s_reg.pwr;
   assign host_valid = s_reg.ovalid;
   assign host_data = s_reg.odata;
   assign host_xfer = s_reg.xfer;
   assign announce_valid = s_reg.annv;
   assign announce_count = s_reg.annc;
   assign hgpio_out = s_reg.hout;
   assign hgpio_oe = s_reg.hoe;
   assign hgpio_rdata = s_reg.hsync2;
endmodule

//--- verification/psc_properties.sv
/*
 Port checker for the sequencer core.
 Assumes it is bound to psc_core and sees only that module's ports.
*/
`timescale 1ns/1ps
module psc_properties (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic core_start,
   input wire logic core_running,
   input wire logic [3:0][15:0] port_oe,
   input wire logic pbus_oe,
   input wire logic pbus_rd_n,
   input wire logic pbus_wr_n,
   input wire logic host_valid,
   input wire logic host_ready,
   input wire logic [15:0] host_data,
   input wire logic announce_valid,
   input wire logic [23:0] announce_count,
   input wire logic [15:0] hgpio_wdata,
   input wire logic [15:0] hgpio_dir,
   input wire logic [15:0] hgpio_out,
   input wire logic [15:0] hgpio_oe
);
   // --------------------
   // Properties
   // --------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic halves_ok;
   // A read strobe spans four cycles and then lifts.
   sequence rd_burst;
      !pbus_rd_n [*4] ##1 pbus_rd_n;
   endsequence
   always_comb begin
      halves_ok = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (port_oe[i / 2][(i % 2) * 8 +: 8] != 8'h00 &&
            port_oe[i / 2][(i % 2) * 8 +: 8] != 8'hFF) begin
            halves_ok = 1'b0;
         end
      end
   end
   reset_clear_a: assert property (
      $fell(rst) |-> !core_running && !host_valid && port_oe == '0 &&
      pbus_rd_n && pbus_wr_n) else $error("outputs not cleared by reset");
   oe_halves_a: assert property (halves_ok)
      else $error("port drive enable split inside a byte half");
   wr_oe_pair_a: assert property (pbus_oe == !pbus_wr_n)
      else $error("data drive and write strobe disagree");
   rd_len_a: assert property ($fell(pbus_rd_n) |-> rd_burst)
      else $error("read strobe length wrong");
   valid_hold_a: assert property (
      host_valid && !host_ready |=> host_valid && $stable(host_data))
      else $error("host word dropped or changed before taken");
   ann_hold_a: assert property (
      $fell(announce_valid) |-> $stable(announce_count))
      else $error("announced count not held");
   stay_halt_a: assert property (
      !core_running && !core_start |=> !core_running)
      else $error("core ran without restart");
   start_run_a: assert property (core_start |=> core_running)
      else $error("core did not start");
   hgpio_reg_a: assert property (
      !$past(rst) |-> hgpio_oe == $past(hgpio_dir) &&
      hgpio_out == $past(hgpio_wdata)) else $error("host group lag wrong");
endmodule

//--- verification/psc_host_model.sv
/*
 Host bridge model: takes words from the core's output stage.
 Assumes one clock; when slow is set it accepts one word in 32 cycles.
*/
`timescale 1ns/1ps
module psc_host_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic slow,
   input wire logic host_valid,
   input wire logic [15:0] host_data,
   output logic host_ready
);
   logic [15:0] words[$];
   logic [4:0] gap_reg;
   initial host_ready = 1'b0;
   always @(posedge clk_sys) begin
      if (host_valid === 1'b1 && host_ready === 1'b1) begin
         words.push_back(host_data);
      end
      if (rst) begin
         words.delete();
      end
      gap_reg <= rst ? 5'h00 : gap_reg + 5'h01;
      host_ready <= #1 !rst && (!slow || gap_reg == 5'h1F);
   end
endmodule

//--- verification/tb.sv
/*
 Self-checking bench: loads small programs into the core, runs them and
 judges ports, peripheral bus and host words.
 Assumes the host model and the property checker files.
*/
`timescale 1ns/1ps
module tb;
   logic clk_sys, rst, prog_we, core_start, core_running, pbus_oe;
   logic pbus_rd_n, pbus_wr_n, host_valid, host_ready, host_xfer, slow;
   logic announce_valid;
   logic [11:0] prog_addr;
   logic [31:0] prog_wdata, wr_cap;
   logic [3:0][15:0] port_in, port_out, port_oe;
   logic [15:0] pbus_addr, pbus_dout, pbus_din, host_data, hgpio_wdata;
   logic [15:0] hgpio_dir, hgpio_in, hgpio_out, hgpio_oe, hgpio_rdata;
   logic [15:0] rd_a;
   logic [23:0] announce_count, ann_cnt;
   logic [31:0] pg[$];
   int bad_count, checks, n, early;
   psc_core dut_u (.clk_sys, .rst, .prog_we, .prog_addr, .prog_wdata,
      .core_start, .core_running, .port_in, .port_out, .port_oe,
      .pbus_addr, .pbus_dout, .pbus_oe, .pbus_din, .pbus_rd_n, .pbus_wr_n,
      .host_valid, .host_ready, .host_data, .host_xfer, .announce_valid,
      .announce_count, .hgpio_wdata, .hgpio_dir, .hgpio_in, .hgpio_out,
      .hgpio_oe, .hgpio_rdata);
   psc_host_model hm_u (.clk_sys, .rst, .slow, .host_valid, .host_data,
      .host_ready);
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Released data lines show a pattern unlike the read value.
   always @(posedge clk_sys) begin
      pbus_din <= #1 pbus_rd_n ? 16'hA5A5 : 16'h5A5A;
      if (announce_valid === 1'b1) ann_cnt <= announce_count;
      if (pbus_wr_n === 1'b0) wr_cap <= {pbus_addr, pbus_dout};
      if (pbus_rd_n === 1'b0) rd_a <= pbus_addr;
      if (rst) early <= 0;
      else if (host_valid && host_ready && core_running) early <= early + 1;
   end
   // --------------------
   // Helpers
   // --------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [63:0] got, exp, input string what);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic limit_hit(input string what);
      bad_count++;
      $display("MISMATCH t=%0t %s", $time, what);
      close_out();
   endtask
   function automatic logic [31:0] ins(logic [5:0] op, logic [2:0] rd,
      logic [2:0] rs, logic [1:0] sl, logic [15:0] imm);
      return {op, rd, rs, sl, 2'h0, imm};
   endfunction
   task automatic step(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   task automatic boot();
      rst = 1'b1;
      step(4);
      rst = 1'b0;
      foreach (pg[i]) begin
         prog_we = 1'b1;
         prog_addr = i[11:0];
         prog_wdata = pg[i];
         step(1);
      end
      prog_we = 1'b0;
      core_start = 1'b1;
      step(1);
      core_start = 1'b0;
   endtask
   task automatic wait_halt(input int lim);
      n = 0;
      while (core_running !== 1'b0 && n < lim) begin
         step(1);
         n++;
      end
      if (core_running !== 1'b0) begin
         limit_hit("core never stopped");
      end
   endtask
   task automatic wait_words(input int cnt, input int lim);
      n = 0;
      while (hm_u.words.size() < cnt && n < lim) begin
         step(1);
         n++;
      end
      if (hm_u.words.size() < cnt) begin
         limit_hit("host words missing");
      end
   endtask
   task automatic hold_len(input logic [15:0] v, input int exp);
      n = 0;
      while (port_out[0] !== v && n < 50) begin
         step(1);
         n++;
      end
      if (port_out[0] !== v) begin
         limit_hit("port value never shown");
      end else begin
         n = 0;
         while (port_out[0] === v && n < 50) begin
            step(1);
            n++;
         end
         if (n >= 50) begin
            limit_hit("port value held too long");
         end else begin
            cmp(n, exp, "hold cycles");
         end
      end
   endtask
   // --------------------
   // Scenarios
   // --------------------
   task automatic t_ports();
      pg = '{ins(psc_pkg::OP_DIR, 0, 0, psc_pkg::SEL_IMM, 16'h0003),
         {psc_pkg::OP_WAVE, 2'h0, 8'h05, 16'h00A5},
         ins(psc_pkg::OP_OUTP, 0, 0, psc_pkg::SEL_IMM, 16'h0F0F),
         {psc_pkg::OP_WAIT, 26'h000000A},
         ins(psc_pkg::OP_OUTP, 0, 0, psc_pkg::SEL_IMM, 16'h1234),
         ins(psc_pkg::OP_HALT, 0, 0, 0, 0)};
      boot();
      hold_len(16'h00A5, 5);
      hold_len(16'h0F0F, 11);
      cmp(port_out[0], 16'h1234, "last port value");
      cmp(port_oe, 64'h000000000000FFFF, "port enables");
      wait_halt(50);
      $display("test ports done");
   endtask
   task automatic t_match(input logic [15:0] ms, pat, input int b,
      input logic lvl);
      pg = '{ins(psc_pkg::OP_MSET, 0, 0, psc_pkg::SEL_IMM, ms),
         ins(psc_pkg::OP_MATCH, 3'h4, 0, psc_pkg::SEL_IMM, pat),
         ins(psc_pkg::OP_OUTP, 3'h1, 0, psc_pkg::SEL_IMM, 16'h0055),
         ins(psc_pkg::OP_HALT, 0, 0, 0, 0)};
      port_in = '0;
      port_in[2][b] = !lvl;
      boot();
      step(20);
      cmp(port_out[1], 16'h0000, "early match");
      port_in[2][b] = lvl;
      wait_halt(12);
      cmp(port_out[1], 16'h0055, "after match");
      $display("test match done");
   endtask
   task automatic t_pbus();
      pg = '{ins(psc_pkg::OP_MOVR, 3, 0, psc_pkg::SEL_IMM, 16'hBEEF),
         ins(psc_pkg::OP_PWR, 0, 3, psc_pkg::SEL_REG, 16'h0040),
         ins(psc_pkg::OP_PRD, 4, 0, psc_pkg::SEL_IMM, 16'h0041),
         ins(psc_pkg::OP_FIFO, 0, 4, psc_pkg::SEL_REG, 0),
         ins(psc_pkg::OP_FLUSH, 0, 0, 0, 0),
         ins(psc_pkg::OP_HALT, 0, 0, 0, 0)};
      boot();
      wait_halt(50);
      step(10);
      cmp(wr_cap, 32'h0040BEEF, "bus write");
      cmp(rd_a, 16'h0041, "read address");
      cmp(hm_u.words.size(), 1, "flushed count");
      cmp(hm_u.words[0], 16'h5A5A, "read word");
      $display("test pbus done");
   endtask
   task automatic t_hgpio();
      hgpio_dir = 16'hF00F;
      hgpio_wdata = 16'h1234;
      hgpio_in = 16'hA5C3;
      step(3);
      cmp({hgpio_oe, hgpio_out}, 32'hF00F1234, "host group");
      cmp(hgpio_rdata, 16'hA5C3, "host group in");
      $display("test hgpio done");
   endtask
   task automatic t_fifo();
      pg = '{{psc_pkg::OP_ANN, 26'h000012C},
         ins(psc_pkg::OP_FIFO, 0, 0, psc_pkg::SEL_ACC, 0),
         ins(psc_pkg::OP_ADD, 0, 0, psc_pkg::SEL_IMM, 16'h0001),
         ins(psc_pkg::OP_CMP, 0, 0, psc_pkg::SEL_ACC, 16'h012C),
         ins(psc_pkg::OP_JL, 0, 0, 0, 16'h0001),
         ins(psc_pkg::OP_ADDR, 1, 0, psc_pkg::SEL_IMM, 16'h0001),
         ins(psc_pkg::OP_NOP, 0, 0, 0, 0),
         ins(psc_pkg::OP_ST, 0, 1, psc_pkg::SEL_REG, 16'h0005),
         ins(psc_pkg::OP_LD, 2, 0, psc_pkg::SEL_IMM, 16'h0005),
         ins(psc_pkg::OP_FIFO, 0, 2, psc_pkg::SEL_REG, 0),
         ins(psc_pkg::OP_FLUSH, 0, 0, 0, 0),
         ins(psc_pkg::OP_HALT, 0, 0, 0, 0)};
      slow = 1'b1;
      boot();
      wait_halt(20000);
      wait_words(301, 20000);
      cmp(ann_cnt, 24'd300, "announced");
      cmp(announce_valid, 1'b0, "announce pulse ended");
      cmp(host_xfer, 1'b0, "transfer session ended");
      cmp(hm_u.words.size(), 301, "word count");
      cmp(early > 0, 1'b1, "auto transfer");
      for (int i = 0; i < 300; i++) begin
         cmp(hm_u.words[i], i, "stream word");
      end
      cmp(hm_u.words[300], 16'd300, "slot count");
      $display("test fifo done");
   endtask
   initial begin
      rst = 1'b1;
      prog_we = 1'b0;
      prog_addr = '0;
      prog_wdata = '0;
      core_start = 1'b0;
      port_in = '0;
      hgpio_wdata = '0;
      hgpio_dir = '0;
      hgpio_in = '0;
      slow = 1'b0;
      bad_count = 0;
      checks = 0;
      step(4);
      rst = 1'b0;
      cmp({core_running, host_valid, pbus_rd_n, pbus_wr_n}, 4'h3,
         "reset state");
      cmp(port_oe, 64'h0, "reset enables");
      $display("test reset done");
      t_ports();
      t_match(16'h0001, 16'h0002, 1, 1'b1);
      t_match(16'h0012, 16'h0004, 2, 1'b0);
      t_pbus();
      t_hgpio();
      t_fifo();
      close_out();
   end
endmodule
bind psc_core psc_properties chk_u (.clk_sys, .rst, .core_start,
   .core_running, .port_oe, .pbus_oe, .pbus_rd_n, .pbus_wr_n, .host_valid,
   .host_ready, .host_data, .announce_valid, .announce_count,
   .hgpio_wdata, .hgpio_dir, .hgpio_out, .hgpio_oe);
